// ==== pkg/sac_defines.vh ====
// register map, field positions, reset values and counts of the converter control block
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// ============================================================
// register byte offsets
`define SAC_OFS_CTRL      8'h00
`define SAC_OFS_RES_HIGH  8'h04
`define SAC_OFS_RES_LOW   8'h08
`define SAC_OFS_CLK       8'h0C
`define SAC_OFS_PDATA     8'h10
`define SAC_OFS_PDIR      8'h14
`define SAC_OFS_PPIN      8'h18

// ============================================================
// status and control fields
`define SAC_CTRL_DONE     7
`define SAC_CTRL_IRQEN    6
`define SAC_CTRL_CONT     5
`define SAC_CH_HI         4
`define SAC_CH_OFF        5'h1F
`define SAC_CH_RST        5'h1F

// ============================================================
// clock register fields
`define SAC_CLK_DIV_HI    7
`define SAC_CLK_DIV_LO    5
`define SAC_CLK_SRC       4
`define SAC_CLK_FMT_HI    3
`define SAC_CLK_FMT_LO    2
`define SAC_CLK_RST       8'h00
`define SAC_CLK_DIV_RST   3'h0

// ============================================================
// result formats
`define SAC_FMT_LEFT      2'h0
`define SAC_FMT_RIGHT     2'h1
`define SAC_FMT_SIGNED    2'h2
`define SAC_FMT_TRUNC     2'h3

// ============================================================
// conversion timing in converter clock ticks, and the first trial code
`define SAC_CONV_TICKS    5'h10
`define SAC_SAR_STEPS     5'h0A
`define SAC_CODE_TOP      10'h200

// ============================================================
// bus answers
`define SAC_RESP_OKAY     2'h0
`define SAC_RESP_SLVERR   2'h2

`endif

// ==== src/sac_control.v ====
// converter control: conversion sequencing, result formats, pin takeover, AXI4-Lite registers
// Function
// - a write of the status and control register starts a conversion unless its channel select is all ones
// - a conversion lasts 16 converter clock ticks from its start
// - continuous mode overwrites the result whether read or not, except in left formats while the high byte is read and the low byte is not
// - continuous mode restarts conversions back to back until its bit clears
// - done flag sets at conversion end, holds until the result is read
// - single mode performs one conversion per control write, then idles
// - selected pin is forced to input; port data and direction writes ignored
// - port read of the selected pin returns zero
// - unselected shared pins stay under normal port control
// - raw code is 3FF at high reference, 000 at low, linear between
// - two-bit format field in the clock register picks one of four formats
// - left format: upper eight bits in high byte, lowest two in low byte
// - left format stores nothing new until low byte read after high byte
// - right format: upper two bits in high byte, lower eight in low byte
// - signed left format is left format with the result msb inverted
// - truncation: upper eight bits in low byte, no byte interlock
// - one of 24 external channels is routed to the converter by channel select
// - at completion store result and, in the same cycle, set flag or raise request per configuration
// - with interrupt enable set the done flag never sets and reads zero
// - request raised per conversion end, cleared by result read or control write
// - channel select all ones switches the converter off
// - five-bit channel select, 32 codes, 24 mapped to external inputs
`timescale 1ns/1ps
`include "sac_defines.vh"

module sac_control #(
	parameter NUM_PINS = 24,
	parameter ADDR_W   = 8
) (
	input  wire                clock,
	input  wire                resetn,
	input  wire [ADDR_W-1:0]   s_axi_awaddr,
	input  wire                s_axi_awvalid,
	output reg                 s_axi_awready,
	input  wire [31:0]         s_axi_wdata,
	input  wire [3:0]          s_axi_wstrb,
	input  wire                s_axi_wvalid,
	output reg                 s_axi_wready,
	output reg  [1:0]          s_axi_bresp,
	output reg                 s_axi_bvalid,
	input  wire                s_axi_bready,
	input  wire [ADDR_W-1:0]   s_axi_araddr,
	input  wire                s_axi_arvalid,
	output reg                 s_axi_arready,
	output reg  [31:0]         s_axi_rdata,
	output reg  [1:0]          s_axi_rresp,
	output reg                 s_axi_rvalid,
	input  wire                s_axi_rready,
	input  wire                compAbove,
	output reg  [9:0]          sarCode,
	output reg  [4:0]          muxSelect,
	output reg                 converterOn,
	output reg                 convIrq,
	input  wire [NUM_PINS-1:0] portPinIn,
	output reg  [NUM_PINS-1:0] portPinOut,
	output reg  [NUM_PINS-1:0] portPinOe
);

	localparam ST_IDLE = 2'b01;
	localparam ST_CONV = 2'b10;

	// ============================================================
	// functions
	function [15:0] formatResult;
		input [9:0] code;
		input [1:0] fmt;
		begin
			case (fmt)
				`SAC_FMT_LEFT:   formatResult = {code[9:2], code[1:0], 6'h00};
				`SAC_FMT_RIGHT:  formatResult = {6'h00, code[9:8], code[7:0]};
				`SAC_FMT_SIGNED: formatResult = {~code[9], code[8:2], code[1:0], 6'h00};
				`SAC_FMT_TRUNC:  formatResult = {8'h00, code[9:2]};
				default:         formatResult = 16'h0000;
			endcase
		end
	endfunction

	function [31:0] mergeStrobe;
		input [31:0] oldVal;
		input [31:0] newVal;
		input [3:0]  strb;
		integer k;
		begin
			mergeStrobe = oldVal;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k]) begin
					mergeStrobe[k*8 +: 8] = newVal[k*8 +: 8];
				end
			end
		end
	endfunction

	// ============================================================
	// synchronisers
	reg  [NUM_PINS-1:0] pinMeta_ff;
	reg  [NUM_PINS-1:0] pinSync_ff;
	reg                 compMeta_ff;
	reg                 compSync_ff;

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pinMeta_ff  <= {NUM_PINS{1'b0}};
			pinSync_ff  <= {NUM_PINS{1'b0}};
			compMeta_ff <= 1'b0;
			compSync_ff <= 1'b0;
		end else begin
			pinMeta_ff  <= portPinIn;
			pinSync_ff  <= pinMeta_ff;
			compMeta_ff <= compAbove;
			compSync_ff <= compMeta_ff;
		end
	end

	// ============================================================
	// bus slave handshake
	reg  [ADDR_W-1:0]   awAddr_ff;
	reg                 awHeld_ff;
	reg  [31:0]         wData_ff;
	reg  [3:0]          wStrb_ff;
	reg                 wHeld_ff;
	wire                awTake = s_axi_awvalid & s_axi_awready;
	wire                wTake  = s_axi_wvalid & s_axi_wready;
	wire                arTake = s_axi_arvalid & s_axi_arready;
	wire                doWrite = awHeld_ff & wHeld_ff & ~s_axi_bvalid;

	wire                wrCtrl  = doWrite & (awAddr_ff == `SAC_OFS_CTRL) & wStrb_ff[0];
	wire                wrClk   = doWrite & (awAddr_ff == `SAC_OFS_CLK) & wStrb_ff[0];
	wire                wrPData = doWrite & (awAddr_ff == `SAC_OFS_PDATA);
	wire                wrPDir  = doWrite & (awAddr_ff == `SAC_OFS_PDIR);
	wire                wrKnown = (awAddr_ff == `SAC_OFS_CTRL) | (awAddr_ff == `SAC_OFS_RES_HIGH) |
	                              (awAddr_ff == `SAC_OFS_RES_LOW) | (awAddr_ff == `SAC_OFS_CLK) |
	                              (awAddr_ff == `SAC_OFS_PDATA) | (awAddr_ff == `SAC_OFS_PDIR) |
	                              (awAddr_ff == `SAC_OFS_PPIN);
	wire                rdHigh  = arTake & (s_axi_araddr == `SAC_OFS_RES_HIGH);
	wire                rdLow   = arTake & (s_axi_araddr == `SAC_OFS_RES_LOW);
	wire                rdResult = rdHigh | rdLow;

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			awAddr_ff     <= {ADDR_W{1'b0}};
			awHeld_ff     <= 1'b0;
			wData_ff      <= 32'h00000000;
			wStrb_ff      <= 4'h0;
			wHeld_ff      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SAC_RESP_OKAY;
		end else begin
			if (awTake) begin
				awAddr_ff <= s_axi_awaddr;
			end
			if (wTake) begin
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
			awHeld_ff     <= (awHeld_ff | awTake) & ~doWrite;
			wHeld_ff      <= (wHeld_ff | wTake) & ~doWrite;
			s_axi_awready <= ~awHeld_ff & ~awTake & ~s_axi_bvalid;
			s_axi_wready  <= ~wHeld_ff & ~wTake & ~s_axi_bvalid;
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrKnown ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ============================================================
	// control, clock and port registers
	reg                 irqEn_ff;
	reg                 contEn_ff;
	reg  [4:0]          chanSel_ff;
	reg  [2:0]          clkDiv_ff;
	reg                 clkSrc_ff;
	reg  [1:0]          resFmt_ff;
	reg  [NUM_PINS-1:0] portData_ff;
	reg  [NUM_PINS-1:0] portDir_ff;
	wire                chanExt = (chanSel_ff < NUM_PINS);
	wire [NUM_PINS-1:0] takenPin = chanExt ? ({{(NUM_PINS-1){1'b0}}, 1'b1} << chanSel_ff) : {NUM_PINS{1'b0}};
	wire [31:0]         dataMerged = mergeStrobe({{(32-NUM_PINS){1'b0}}, portData_ff}, wData_ff, wStrb_ff);
	wire [31:0]         dirMerged  = mergeStrobe({{(32-NUM_PINS){1'b0}}, portDir_ff}, wData_ff, wStrb_ff);

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			irqEn_ff    <= 1'b0;
			contEn_ff   <= 1'b0;
			chanSel_ff  <= `SAC_CH_RST;
			clkDiv_ff   <= `SAC_CLK_DIV_RST;
			clkSrc_ff   <= 1'b0;
			resFmt_ff   <= `SAC_FMT_LEFT;
			portData_ff <= {NUM_PINS{1'b0}};
			portDir_ff  <= {NUM_PINS{1'b0}};
		end else begin
			if (wrCtrl) begin
				irqEn_ff   <= wData_ff[`SAC_CTRL_IRQEN];
				contEn_ff  <= wData_ff[`SAC_CTRL_CONT];
				chanSel_ff <= wData_ff[`SAC_CH_HI:0];
			end
			if (wrClk) begin
				clkDiv_ff <= wData_ff[`SAC_CLK_DIV_HI:`SAC_CLK_DIV_LO];
				clkSrc_ff <= wData_ff[`SAC_CLK_SRC];
				resFmt_ff <= wData_ff[`SAC_CLK_FMT_HI:`SAC_CLK_FMT_LO];
			end
			// the pin held by the converter keeps its old port bits
			if (wrPData) begin
				portData_ff <= (dataMerged[NUM_PINS-1:0] & ~takenPin) | (portData_ff & takenPin);
			end
			if (wrPDir) begin
				portDir_ff <= (dirMerged[NUM_PINS-1:0] & ~takenPin) | (portDir_ff & takenPin);
			end
		end
	end

	// ============================================================
	// pin drive and converter outputs
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			portPinOut  <= {NUM_PINS{1'b0}};
			portPinOe   <= {NUM_PINS{1'b0}};
			muxSelect   <= `SAC_CH_RST;
			converterOn <= 1'b0;
		end else begin
			portPinOut  <= portData_ff & ~takenPin;
			portPinOe   <= portDir_ff & ~takenPin;
			muxSelect   <= chanSel_ff;
			converterOn <= (chanSel_ff != `SAC_CH_OFF);
		end
	end

	// ============================================================
	// converter clock prescaler
	reg  [8:0]          preCnt_ff;
	wire [8:0]          preLimit = (9'h001 << ({1'b0, clkDiv_ff} + {3'h0, clkSrc_ff})) - 9'h001;
	wire                convTick = (preCnt_ff == preLimit);
	wire                startConv = wrCtrl & (wData_ff[`SAC_CH_HI:0] != `SAC_CH_OFF);

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			preCnt_ff <= 9'h000;
		end else if (startConv | convTick) begin
			preCnt_ff <= 9'h000;
		end else begin
			preCnt_ff <= preCnt_ff + 9'h001;
		end
	end

	// ============================================================
	// successive approximation sequencer
	reg  [1:0]          state_ff;
	reg  [1:0]          nxt_state;
	reg  [4:0]          step_ff;
	reg  [9:0]          nxt_sar;
	wire [3:0]          bitIdx = 4'hA - step_ff[3:0];
	wire                convEnd = (state_ff == ST_CONV) & convTick & (step_ff == `SAC_CONV_TICKS - 5'h01);

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (startConv) begin
					nxt_state = ST_CONV;
				end
			end
			ST_CONV: begin
				if (wrCtrl & ~startConv) begin
					nxt_state = ST_IDLE;
				end else if (convEnd & ~startConv & ~contEn_ff) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// comparator high keeps the trial bit, so full scale yields all ones
	always @* begin
		nxt_sar = sarCode;
		if (step_ff == 5'h00) begin
			nxt_sar = `SAC_CODE_TOP;
		end else if (step_ff <= `SAC_SAR_STEPS) begin
			nxt_sar[bitIdx] = compSync_ff;
			if (bitIdx != 4'h0) begin
				nxt_sar[bitIdx - 4'h1] = 1'b1;
			end
		end
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_IDLE;
			step_ff  <= 5'h00;
			sarCode  <= 10'h000;
		end else begin
			state_ff <= nxt_state;
			if (startConv | convEnd) begin
				step_ff <= 5'h00;
				sarCode <= 10'h000;
			end else if ((state_ff == ST_CONV) & convTick) begin
				step_ff <= step_ff + 5'h01;
				sarCode <= nxt_sar;
			end
		end
	end

	// ============================================================
	// result store, interlock, done flag and request
	reg  [7:0]          resHigh_ff;
	reg  [7:0]          resLow_ff;
	reg                 highRead_ff;
	reg                 doneFlag_ff;
	wire                leftFmt = (resFmt_ff == `SAC_FMT_LEFT) | (resFmt_ff == `SAC_FMT_SIGNED);
	wire                storeOk = ~(highRead_ff & leftFmt);
	wire [15:0]         formatted = formatResult(nxt_sar, resFmt_ff);

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			resHigh_ff  <= 8'h00;
			resLow_ff   <= 8'h00;
			highRead_ff <= 1'b0;
			doneFlag_ff <= 1'b0;
			convIrq     <= 1'b0;
		end else begin
			if (convEnd & storeOk) begin
				resHigh_ff <= formatted[15:8];
				resLow_ff  <= formatted[7:0];
			end
			if (rdLow | ~leftFmt) begin
				highRead_ff <= 1'b0;
			end else if (rdHigh) begin
				highRead_ff <= 1'b1;
			end
			if (convEnd & ~irqEn_ff) begin
				doneFlag_ff <= 1'b1;
			end else if (rdResult | irqEn_ff) begin
				doneFlag_ff <= 1'b0;
			end
			if (convEnd & irqEn_ff) begin
				convIrq <= 1'b1;
			end else if (rdResult | wrCtrl) begin
				convIrq <= 1'b0;
			end
		end
	end

	// ============================================================
	// read channel
	reg  [31:0]         rdMux;
	reg                 rdHit;

	always @* begin
		rdMux = 32'h00000000;
		rdHit = 1'b1;
		case (s_axi_araddr)
			`SAC_OFS_CTRL:     rdMux = {24'h000000, doneFlag_ff & ~irqEn_ff, irqEn_ff, contEn_ff, chanSel_ff};
			`SAC_OFS_RES_HIGH: rdMux = {24'h000000, resHigh_ff};
			`SAC_OFS_RES_LOW:  rdMux = {24'h000000, resLow_ff};
			`SAC_OFS_CLK:      rdMux = {24'h000000, clkDiv_ff, clkSrc_ff, resFmt_ff, 2'h0};
			`SAC_OFS_PDATA:    rdMux = {{(32-NUM_PINS){1'b0}}, portData_ff};
			`SAC_OFS_PDIR:     rdMux = {{(32-NUM_PINS){1'b0}}, portDir_ff};
			`SAC_OFS_PPIN:     rdMux = {{(32-NUM_PINS){1'b0}}, pinSync_ff & ~takenPin};
			default:           rdHit = 1'b0;
		endcase
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SAC_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~arTake;
			if (arTake) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdMux;
				s_axi_rresp  <= rdHit ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// ==== tb/sac_analog_model.sv ====
// analog front end: comparator of the selected input against the trial code
`timescale 1ns/1ps
module sac_analog_model (
	input  wire       clock,
	input  wire [9:0] sarCode,
	input  wire       converterOn,
	input  wire [9:0] vinCode,
	output wire       compAbove
);
	reg flip_ff = 1'b0;
	always @(posedge clock)
		flip_ff <= ~flip_ff;
	// powered down: nothing settles, so the output wanders
	assign compAbove = converterOn ? (vinCode >= sarCode) : flip_ff;
endmodule

// ==== tb/sac_control_checker.sv ====
// concurrent checks on the converter control ports
`timescale 1ns/1ps
`include "sac_defines.vh"
module sac_control_checker #(
	parameter NUM_PINS = 24,
	parameter ADDR_W   = 8
) (
	input wire                clock,
	input wire                resetn,
	input wire [ADDR_W-1:0]   s_axi_awaddr,
	input wire                s_axi_awvalid,
	input wire                s_axi_awready,
	input wire [31:0]         s_axi_wdata,
	input wire                s_axi_wvalid,
	input wire                s_axi_bvalid,
	input wire                s_axi_bready,
	input wire [ADDR_W-1:0]   s_axi_araddr,
	input wire                s_axi_arvalid,
	input wire                s_axi_arready,
	input wire                s_axi_rvalid,
	input wire [9:0]          sarCode,
	input wire [4:0]          muxSelect,
	input wire                converterOn,
	input wire                convIrq,
	input wire [NUM_PINS-1:0] portPinOut,
	input wire [NUM_PINS-1:0] portPinOe
);
	reg  [9:0] sinceCtrl_ff;
	reg        wasCtrl_ff;
	wire       ctrlTake = s_axi_awvalid && s_axi_awready && s_axi_awaddr == `SAC_OFS_CTRL;
	wire       resRead  = s_axi_araddr == `SAC_OFS_RES_HIGH || s_axi_araddr == `SAC_OFS_RES_LOW;
	// cycles since the last control write was answered, saturating
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sinceCtrl_ff <= 10'h3FF;
			wasCtrl_ff   <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				wasCtrl_ff <= ctrlTake;
			if (s_axi_bvalid && s_axi_bready && wasCtrl_ff)
				sinceCtrl_ff <= 10'h000;
			else if (sinceCtrl_ff != 10'h3FF)
				sinceCtrl_ff <= sinceCtrl_ff + 10'h001;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence ctrlStart;
		ctrlTake && s_axi_wvalid && s_axi_wdata[4:0] != `SAC_CH_OFF;
	endsequence
	sequence ctrlOff;
		ctrlTake && s_axi_wvalid && s_axi_wdata[4:0] == `SAC_CH_OFF;
	endsequence
	// ==========================================================
	// properties
	a_start_trial: assert property (ctrlStart |-> ##[1:600] sarCode == `SAC_CODE_TOP)
		else $error("no first trial code after control write");
	a_on_after_write: assert property (ctrlStart |-> ##[1:4] converterOn)
		else $error("converter not on after channel select");
	a_off_after_write: assert property (ctrlOff |-> ##[1:4] !converterOn)
		else $error("converter not off after all-ones select");
	a_pin_forced_in: assert property ($stable(muxSelect) && muxSelect < NUM_PINS |->
		!portPinOe[muxSelect] && !portPinOut[muxSelect])
		else $error("selected pin still driven");
	a_conv_min_time: assert property ($rose(convIrq) |-> sinceCtrl_ff >= 10'h010)
		else $error("conversion ended too early");
	a_read_clears_irq: assert property (s_axi_arvalid && s_axi_arready && resRead |-> ##[1:3] !convIrq)
		else $error("result read left request set");
	a_write_clears_irq: assert property (ctrlTake |-> ##[1:3] !convIrq)
		else $error("control write left request set");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
endmodule

bind sac_control sac_control_checker #(.NUM_PINS(NUM_PINS), .ADDR_W(ADDR_W)) chk_u (
	.clock(clock), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.sarCode(sarCode), .muxSelect(muxSelect), .converterOn(converterOn), .convIrq(convIrq),
	.portPinOut(portPinOut), .portPinOe(portPinOe));

// ==== tb/tb_top.sv ====
// self-checking bench of the converter control block
`timescale 1ns/1ps
`include "sac_defines.vh"
module tb_top;
	localparam [71:0] TAB = {12'h2D6, 12'h7FF, 12'h400, 12'hAD6, 12'hED6, 12'h555};
	reg         clock, resetn, awValid, wValid, bReady, arValid, rReady;
	reg  [7:0]  awAddr, arAddr;
	reg  [31:0] wData, d;
	reg  [9:0]  vinCode;
	reg  [23:0] pinIn;
	reg  [11:0] e;
	reg  [1:0]  r, f;
	wire        awReady, wReady, bValid, arReady, rValid, compAbove, convOn, convIrq;
	wire [1:0]  bResp, rResp;
	wire [31:0] rData;
	wire [9:0]  sarCode;
	wire [4:0]  muxSel;
	wire [23:0] pinOut, pinOe;
	integer     n_errors, compares, cycles, i, n;
	sac_control dut_u (.clock(clock), .resetn(resetn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .compAbove(compAbove),
		.sarCode(sarCode), .muxSelect(muxSel), .converterOn(convOn), .convIrq(convIrq),
		.portPinIn(pinIn), .portPinOut(pinOut), .portPinOe(pinOe));
	sac_analog_model model_u (.clock(clock), .sarCode(sarCode), .converterOn(convOn), .vinCode(vinCode),
		.compAbove(compAbove));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			give_verdict;
		end
	end
	// ==========================================================
	// tasks
	task give_verdict;
		begin
			$display("compares %0d n_errors %0d", compares, n_errors);
			if (n_errors == 0 && compares > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task chk(input [127:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("BAD %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		reg ad, dd;
		begin
			awAddr <= a;
			wData <= v;
			awValid <= 1'b1;
			wValid <= 1'b1;
			bReady <= 1'b1;
			ad = 1'b0;
			dd = 1'b0;
			while (!(ad && dd)) begin
				@(posedge clock);
				if (!ad && awReady) begin
					ad = 1'b1;
					awValid <= 1'b0;
				end
				if (!dd && wReady) begin
					dd = 1'b1;
					wValid <= 1'b0;
				end
			end
			@(posedge clock);
			while (!bValid) @(posedge clock);
			r = bResp;
			bReady <= 1'b0;
			@(posedge clock);
		end
	endtask
	task rd(input [7:0] a);
		begin
			arAddr <= a;
			arValid <= 1'b1;
			rReady <= 1'b1;
			@(posedge clock);
			while (!arReady) @(posedge clock);
			arValid <= 1'b0;
			@(posedge clock);
			while (!rValid) @(posedge clock);
			d = rData;
			r = rResp;
			rReady <= 1'b0;
			@(posedge clock);
		end
	endtask
	task wait_irq;
		for (n = 0; !convIrq && n < 2000; n = n + 1) @(posedge clock);
	endtask
	task conv(input [9:0] v);
		begin
			vinCode <= v;
			wr(`SAC_OFS_CTRL, 32'h05);
			d = 0;
			for (n = 0; !d[7] && n < 300; n = n + 1) rd(`SAC_OFS_CTRL);
			chk("done flag", d[7], 1'b1);
		end
	endtask
	function [31:0] exp_hi(input [1:0] f, input [9:0] c);
		exp_hi = (f == `SAC_FMT_RIGHT) ? {30'h0, c[9:8]} : {24'h0, c[9] ^ (f == `SAC_FMT_SIGNED), c[8:2]};
	endfunction
	function [31:0] exp_lo(input [1:0] f, input [9:0] c);
		exp_lo = (f == `SAC_FMT_RIGHT) ? {24'h0, c[7:0]} : (f == `SAC_FMT_TRUNC) ? {24'h0, c[9:2]} :
			{24'h0, c[1:0], 6'h00};
	endfunction
	// ==========================================================
	// main sequence
	initial begin
		{resetn, awValid, wValid, bReady, arValid, rReady} = 6'h00;
		{awAddr, arAddr, wData, vinCode, pinIn} = 82'h0;
		{cycles, n_errors, compares} = 96'h0;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		rd(`SAC_OFS_CTRL);
		chk("ctrl reset", d, 32'h1F);
		chk("conv off", convOn, 1'b0);
		chk("irq idle", convIrq, 1'b0);
		rd(8'h40);
		chk("unmapped rd", d, 32'h0);
		chk("unmapped rresp", r, `SAC_RESP_SLVERR);
		wr(8'h40, 32'h0);
		chk("unmapped wr", r, `SAC_RESP_SLVERR);
		pinIn <= 24'hFFFFFF;
		wr(`SAC_OFS_CLK, 32'h40);
		wr(`SAC_OFS_CTRL, 32'h03);
		wr(`SAC_OFS_PDATA, 32'hFFFFFF);
		wr(`SAC_OFS_PDIR, 32'hFFFFFF);
		chk("mux select", muxSel, 5'h03);
		chk("pin oe", pinOe, 24'hFFFFF7);
		chk("pin out", pinOut, 24'hFFFFF7);
		rd(`SAC_OFS_PPIN);
		chk("pin read", d, 32'hFFFFF7);
		for (i = 0; i < 6; i = i + 1) begin
			e = TAB[i*12 +: 12];
			wr(`SAC_OFS_CLK, {24'h0, 3'h2, 1'h0, e[11:10], 2'h0});
			conv(e[9:0]);
			rd(`SAC_OFS_RES_HIGH);
			if (e[11:10] != `SAC_FMT_TRUNC)
				chk("result high", d, exp_hi(e[11:10], e[9:0]));
			rd(`SAC_OFS_RES_LOW);
			chk("result low", d, exp_lo(e[11:10], e[9:0]));
			rd(`SAC_OFS_CTRL);
			chk("done cleared", d[7], 1'b0);
		end
		chk("pin oe back", pinOe, 24'hFFFFD7);
		wr(`SAC_OFS_CTRL, 32'h45);
		wait_irq;
		chk("conv span", n >= 60 && n <= 70, 1'b1);
		rd(`SAC_OFS_CTRL);
		chk("flag masked", d[7], 1'b0);
		rd(`SAC_OFS_RES_LOW);
		chk("irq read clr", convIrq, 1'b0);
		wr(`SAC_OFS_CTRL, 32'h45);
		wait_irq;
		wr(`SAC_OFS_CTRL, 32'h05);
		chk("irq wr clr", convIrq, 1'b0);
		wr(`SAC_OFS_CLK, 32'h44);
		vinCode <= 10'h1A5;
		wr(`SAC_OFS_CTRL, 32'h65);
		wait_irq;
		rd(`SAC_OFS_RES_LOW);
		chk("cont first", d, 32'hA5);
		vinCode <= 10'h0AB;
		repeat (200) @(posedge clock);
		rd(`SAC_OFS_RES_LOW);
		chk("cont overwrite", d, 32'hAB);
		wr(`SAC_OFS_CTRL, 32'h45);
		wait_irq;
		rd(`SAC_OFS_RES_LOW);
		repeat (200) @(posedge clock);
		chk("single idle", convIrq, 1'b0);
		wr(`SAC_OFS_CTRL, 32'h1F);
		chk("power down", convOn, 1'b0);
		for (i = 0; i < 2; i = i + 1) begin
			f = i ? `SAC_FMT_TRUNC : `SAC_FMT_SIGNED;
			wr(`SAC_OFS_CLK, {24'h0, 3'h2, 1'h0, f, 2'h0});
			conv(10'h2D6);
			rd(`SAC_OFS_RES_HIGH);
			conv(10'h0C3);
			rd(`SAC_OFS_RES_LOW);
			chk("interlock low", d, exp_lo(f, i ? 10'h0C3 : 10'h2D6));
		end
		give_verdict;
	end
endmodule
